// *** sad_pkg.sv ***
// Shared constants of the averaging decimator link and its two ends.
// Assumes both ends run from one 50 MHz core clock each.
package sad_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned RESULT_W = 24;
  localparam int unsigned COUNT_W  = 16;
  localparam int unsigned WORD_W   = RESULT_W + COUNT_W;
  localparam int unsigned ACC_W    = 48;
  localparam int unsigned N_W      = 17;
  localparam int unsigned SCNT_W   = 5;
  localparam int unsigned BITS_W   = 6;
  // ----------------------------------------
  // Filter limits
  // ----------------------------------------
  localparam logic [N_W-1:0]     N_MAX      = 17'h10000;
  localparam logic [N_W-1:0]     N_SAT      = 17'h10001;
  localparam logic [4:0]         SHIFT_MAX  = 5'h10;
  localparam logic [COUNT_W-1:0] COUNT_SAT  = 16'hffff;
  localparam logic signed [ACC_W-1:0] OUT_POS = 48'sh0000007fffff;
  localparam logic signed [ACC_W-1:0] OUT_NEG = -48'sh000000800000;
  // ----------------------------------------
  // Link thresholds
  // ----------------------------------------
  localparam logic [SCNT_W-1:0] SCK_TERM  = 5'h14;
  localparam logic [BITS_W-1:0] SCK_TERM6 = 6'h14;
  localparam logic [BITS_W-1:0] BITS_FULL = 6'h28;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CONV_TIME_NS  = 392;
  localparam int unsigned CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SCK_HALF_CYC  = 4;
  localparam int unsigned TRIG_HIGH_CYC = 2;
endpackage

// *** sad_link_if.sv ***
// Serial link between the averaging converter and its reading host.
// Assumes all four lines are point to point and one way.
interface sad_link_if;
  logic conversion_trigger;
  logic sck;
  logic busy;
  logic sdo;
  modport device (input conversion_trigger, input sck, output busy, output sdo);
  modport host   (output conversion_trigger, output sck, input busy, input sdo);
endinterface

// *** sad_device.sv ***
// Converter end: conversion timing, averaging filter and 40-bit output shifter.
// Assumes SAMPLE_IN carries the converter core result, stable around the trigger.
// Contract
// - Average from 1 up to 65536 results.
// - All averaged samples carry equal weight.
// - Result register holds latest 24-bit sample.
// - Averages load into the output shift register.
// - Reading every cycle mirrors the result register.
// - Host may clock only 20 bits.
// - Keep accumulating while no read started.
// - Read start resets the filter.
// - Average spans read start to read start.
// - Divide by next power of two.
// - Host limits rate for single-cycle reads.
// - Host averages four for fastest rate.
// - 1 to 19 clocks keep output register.
// - First clock starts read; terminate first.
// - 0 or over 19 clocks reload output.
// - Host may split read into groups.
// - Busy high throughout each conversion.
// - Weight stops at 65536, accumulation continues.
// - 16-bit count N-1 follows the result.
// - Count saturates at its maximum value.
module sad_device #(
  parameter int unsigned CONV_CYC = sad_pkg::CONV_CYCLES
) (
  input  wire logic                          CORE_CLK,
  input  wire logic                          RESET_N,
  sad_link_if.device                         LINK,
  input  wire logic [sad_pkg::RESULT_W-1:0]  SAMPLE_IN,
  output logic      [sad_pkg::RESULT_W-1:0]  RESULT_REG,
  output logic                               READ_ACTIVE
);
  import sad_pkg::*;

  generate
    if (CONV_CYC < 1 || CONV_CYC > 255) begin : g_bad_conv
      $error("CONV_CYC must lie in 1..255");
    end
  endgenerate

  localparam logic [7:0] CONV_LAST = 8'(CONV_CYC - 1);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] trig_sync;
  logic [1:0] sck_sync;
  logic       trig_prev;
  logic       sck_prev;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      trig_sync <= 2'h0;
      sck_sync  <= 2'h0;
      trig_prev <= 1'b0;
      sck_prev  <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[0], LINK.conversion_trigger};
      sck_sync  <= {sck_sync[0], LINK.sck};
      trig_prev <= trig_sync[1];
      sck_prev  <= sck_sync[1];
    end
  end

  wire trig_rise = trig_sync[1] & ~trig_prev;
  wire sck_rise  = sck_sync[1] & ~sck_prev;

  // ----------------------------------------
  // Conversion timing
  // ----------------------------------------
  logic                busy;
  logic [7:0]          conv_cnt;
  logic [RESULT_W-1:0] sample;

  // A trigger during a conversion is ignored; a conversion cannot restart
  wire conv_start = trig_rise & ~busy;
  wire conv_done  = busy & (conv_cnt == CONV_LAST);

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      busy     <= 1'b0;
      conv_cnt <= 8'h0;
      sample   <= '0;
    end else if (conv_start) begin
      busy     <= 1'b1;
      conv_cnt <= 8'h0;
      sample   <= SAMPLE_IN;
    end else if (conv_done) begin
      busy     <= 1'b0;
    end else if (busy) begin
      conv_cnt <= conv_cnt + 8'h1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      RESULT_REG <= '0;
    end else if (conv_done) begin
      RESULT_REG <= sample;
    end
  end

  // ----------------------------------------
  // Read tracking
  // ----------------------------------------
  logic              reading;
  logic [SCNT_W-1:0] sck_cnt;

  // Clocks are counted per window between two busy falling edges
  wire terminate  = (sck_cnt == '0) | (sck_cnt >= SCK_TERM);
  wire load_out   = conv_done & terminate;
  // A rise in the very cycle that ends a read opens the next one and clears the filter
  wire read_start = sck_rise & (~reading | load_out);

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      sck_cnt <= '0;
    end else if (conv_done) begin
      sck_cnt <= {{(SCNT_W-1){1'b0}}, sck_rise};
    end else if (sck_rise && sck_cnt < SCK_TERM) begin
      sck_cnt <= sck_cnt + 5'h1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      reading <= 1'b0;
    end else if (load_out) begin
      reading <= sck_rise;
    end else if (read_start) begin
      reading <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      READ_ACTIVE <= 1'b0;
    end else begin
      READ_ACTIVE <= reading;
    end
  end

  // ----------------------------------------
  // Averaging filter
  // ----------------------------------------
  logic signed [ACC_W-1:0] acc;
  logic        [N_W-1:0]   n_avg;

  // Smallest power of two not below n, capped once n passes 65536
  function automatic logic [4:0] weight_shift(input logic [N_W-1:0] n);
    logic [4:0] s;
    s = SHIFT_MAX;
    for (int k = 16; k >= 0; k--) begin
      if ((17'h1 << k) >= n) begin
        s = 5'(k);
      end
    end
    return s;
  endfunction

  wire signed [ACC_W-1:0] sample_ext = {{(ACC_W-RESULT_W){sample[RESULT_W-1]}}, sample};
  // Every sample adds with unit weight: a boxcar of N equal taps
  wire signed [ACC_W-1:0] load_sum   = acc + sample_ext;
  // Counter stops one past 65536 so the count field can still saturate
  wire        [N_W-1:0]   load_n     = (n_avg >= N_SAT) ? N_SAT : n_avg + 17'h1;
  wire        [4:0]       shift_amt  = weight_shift(load_n);
  wire signed [ACC_W-1:0] avg_full   = load_sum >>> shift_amt;
  // Beyond 65536 samples the sum can outgrow the output, so it clips at full scale
  wire        [RESULT_W-1:0] avg_out = (avg_full > OUT_POS) ? OUT_POS[RESULT_W-1:0] :
                                       (avg_full < OUT_NEG) ? OUT_NEG[RESULT_W-1:0] :
                                       avg_full[RESULT_W-1:0];
  wire        [COUNT_W-1:0]  cnt_out = (load_n > N_MAX) ? COUNT_SAT :
                                       16'(load_n - 17'h1);

  // A read start clears the sum; a conversion ending in that same cycle opens the new block
  wire signed [ACC_W-1:0] next_acc = read_start ? (conv_done ? sample_ext : '0) :
                                     (conv_done ? load_sum : acc);
  wire        [N_W-1:0]   next_n   = read_start ? (conv_done ? 17'h1 : '0) :
                                     (conv_done ? load_n : n_avg);

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      acc   <= '0;
      n_avg <= '0;
    end else begin
      acc   <= next_acc;
      n_avg <= next_n;
    end
  end

  // ----------------------------------------
  // Output shift register
  // ----------------------------------------
  logic [WORD_W-1:0] out_shift;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      out_shift <= '0;
    end else if (load_out) begin
      out_shift <= {avg_out, cnt_out};
    end else if (sck_rise) begin
      out_shift <= {out_shift[WORD_W-2:0], 1'b0};
    end
  end

  assign LINK.busy = busy;
  assign LINK.sdo  = out_shift[WORD_W-1];
endmodule

// *** sad_host.sv ***
// Reading end: issues conversion triggers and reads results in groups of clocks.
// Assumes the device answers on the same link interface and a 50 MHz core clock.
module sad_host #(
  parameter int unsigned SCK_HALF  = sad_pkg::SCK_HALF_CYC,
  parameter int unsigned TRIG_HIGH = sad_pkg::TRIG_HIGH_CYC
) (
  input  wire logic                         CORE_CLK,
  input  wire logic                         RESET_N,
  sad_link_if.host                          LINK,
  input  wire logic                         CONV_REQ,
  input  wire logic                         READ_EN,
  input  wire logic [sad_pkg::BITS_W-1:0]   READ_BITS,
  input  wire logic [sad_pkg::BITS_W-1:0]   GROUP_BITS,
  output logic      [sad_pkg::WORD_W-1:0]   DATA_WORD,
  output logic                              DATA_VALID
);
  import sad_pkg::*;

  generate
    if (SCK_HALF < 4 || SCK_HALF > 255 || TRIG_HIGH < 2 || TRIG_HIGH > 255) begin : g_bad
      $error("SCK_HALF needs 4..255 and TRIG_HIGH 2..255");
    end
  endgenerate

  localparam logic [7:0] HALF_LAST = 8'(SCK_HALF - 1);
  localparam logic [7:0] TRIG_LAST = 8'(TRIG_HIGH - 1);

  // ----------------------------------------
  // Conversion trigger
  // ----------------------------------------
  logic       trig;
  logic [7:0] trig_cnt;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      trig     <= 1'b0;
      trig_cnt <= 8'h0;
    end else if (CONV_REQ && !trig) begin
      trig     <= 1'b1;
      trig_cnt <= 8'h0;
    end else if (trig) begin
      trig     <= (trig_cnt != TRIG_LAST);
      trig_cnt <= trig_cnt + 8'h1;
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] busy_sync;
  logic [1:0] sdo_sync;
  logic       busy_prev;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      busy_sync <= 2'h0;
      sdo_sync  <= 2'h0;
      busy_prev <= 1'b0;
    end else begin
      busy_sync <= {busy_sync[0], LINK.busy};
      sdo_sync  <= {sdo_sync[0], LINK.sdo};
      busy_prev <= busy_sync[1];
    end
  end

  wire busy_fall = busy_prev & ~busy_sync[1];

  // ----------------------------------------
  // Read sequencing
  // ----------------------------------------
  logic              in_read;
  logic [BITS_W-1:0] got;
  logic [BITS_W-1:0] window;
  logic [BITS_W-1:0] pulses;
  logic [7:0]        phase;
  logic              sck;

  wire              read_done = in_read & (got >= READ_BITS);
  // A window with 20 or more clocks already ended the read, so no idle window is needed
  wire              restart   = ~in_read | (read_done & (window >= SCK_TERM6));
  wire [BITS_W-1:0] remain    = READ_BITS - got;
  wire [BITS_W-1:0] first_grp = (GROUP_BITS < READ_BITS) ? GROUP_BITS : READ_BITS;
  wire [BITS_W-1:0] next_grp  = (GROUP_BITS < remain) ? GROUP_BITS : remain;
  wire              half_end  = (pulses != '0) & (phase == HALF_LAST);
  wire              rise_now  = half_end & ~sck;
  wire              fall_now  = half_end & sck;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      in_read <= 1'b0;
      got     <= '0;
      pulses  <= '0;
    end else if (busy_fall) begin
      if (READ_EN && restart) begin
        in_read <= 1'b1;
        got     <= '0;
        pulses  <= first_grp;
      end else if (read_done) begin
        in_read <= 1'b0;
        pulses  <= '0;
      end else if (in_read) begin
        pulses  <= next_grp;
      end
    end else begin
      if (rise_now) begin
        got    <= got + 6'h1;
      end
      if (fall_now) begin
        pulses <= pulses - 6'h1;
      end
    end
  end

  // ----------------------------------------
  // Serial clock divider and data capture
  // ----------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      phase  <= 8'h0;
      sck    <= 1'b0;
      window <= '0;
    end else begin
      phase  <= (pulses == '0 || half_end) ? 8'h0 : phase + 8'h1;
      sck    <= sck ^ half_end;
      if (busy_fall) begin
        window <= '0;
      end else if (rise_now && window != 6'h3f) begin
        window <= window + 6'h1;
      end
    end
  end

  // Data is taken just before the rising edge, long after the device shifted
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      DATA_WORD  <= '0;
      DATA_VALID <= 1'b0;
    end else begin
      DATA_VALID <= busy_fall & read_done;
      if (rise_now) begin
        DATA_WORD <= {DATA_WORD[WORD_W-2:0], sdo_sync[1]};
      end
    end
  end

  assign LINK.conversion_trigger = trig;
  assign LINK.sck                = sck;
endmodule

// *** sad_link_properties.sv ***
// Timing relations on the four wires between the converter end and the host end.
// Assumes one core clock for both ends and a synchronous active-low reset.
module sad_link_properties #(
  parameter int unsigned CONV_CYC = 19
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic conversion_trigger,
  input wire logic sck,
  input wire logic busy,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] busy_len;
  logic [5:0] since_trig;
  logic [5:0] since_rise;
  logic [5:0] win;
  wire        trig_sat = since_trig == 6'h3f;
  wire        rise_sat = since_rise == 6'h3f;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  // Window count uses the pin edges; the host clocks well inside each window
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      busy_len   <= 6'h0;
      since_trig <= 6'h3f;
      since_rise <= 6'h3f;
      win        <= 6'h0;
    end else begin
      busy_len   <= busy ? busy_len + 6'h1 : 6'h0;
      since_trig <= $rose(conversion_trigger) ? 6'h0 : (trig_sat ? since_trig : since_trig + 6'h1);
      since_rise <= $rose(sck) ? 6'h0 : (rise_sat ? since_rise : since_rise + 6'h1);
      win        <= $fell(busy) ? 6'($rose(sck)) : win + 6'($rose(sck));
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_busy_length: assert property ($fell(busy) |-> busy_len == 6'(CONV_CYC))
    else $error("busy high time wrong");
  a_busy_cause: assert property ($rose(busy) |-> since_trig >= 6'h1 && since_trig <= 6'h4)
    else $error("busy rose without a fresh trigger");
  a_trig_width: assert property ($rose(conversion_trigger) |-> ##1 conversion_trigger ##1 !conversion_trigger)
    else $error("trigger pulse width wrong");
  a_sdo_moves: assert property ($changed(sdo) |-> $fell(busy) || (since_rise >= 6'h1 && since_rise <= 6'h6))
    else $error("sdo moved without cause");
  a_sdo_kept: assert property ($fell(busy) && win >= 6'h1 && win <= 6'h13 |-> $stable(sdo))
    else $error("output register reloaded in a read");
  a_sck_high: assert property ($rose(sck) |-> sck [*4])
    else $error("sck high too short");
  a_sck_low: assert property ($fell(sck) |-> !sck [*4])
    else $error("sck low too short");
  a_window_max: assert property ($fell(busy) |-> win <= 6'h28)
    else $error("too many clocks in a window");

  c_kept: cover property ($fell(busy) && win >= 6'h1 && win <= 6'h13);
  c_full: cover property ($fell(busy) && win >= 6'h14);
  c_trig_busy: cover property ($rose(conversion_trigger) && busy);
endmodule

// *** tb_top.sv ***
// Bench joining the host end to the converter end over one link interface.
// Assumes the host paces reads; the bench only feeds samples, conversion requests and read settings.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sad_pkg::*;

  logic                core_clk;
  logic                reset_n;
  logic                conv_req;
  logic                read_en;
  logic [BITS_W-1:0]   read_bits;
  logic [BITS_W-1:0]   group_bits;
  logic [RESULT_W-1:0] sample_in;
  logic [RESULT_W-1:0] result_reg;
  logic                read_active;
  logic [WORD_W-1:0]   data_word;
  logic                data_valid;
  integer              seed = 32'hedcb;
  int                  bad_count;
  int                  comparisons;
  longint              sum;
  int                  n;
  int                  rem;
  int                  cprev;
  int                  rbits;
  int                  gbits;
  logic                act;
  logic [79:0]         expq[$];
  logic [79:0]         e;

  // ----------------------------------------
  // Both ends and the link checker
  // ----------------------------------------
  sad_link_if link();
  sad_device u_sad_device (.CORE_CLK(core_clk), .RESET_N(reset_n), .LINK(link), .SAMPLE_IN(sample_in),
    .RESULT_REG(result_reg), .READ_ACTIVE(read_active));
  sad_host u_sad_host (.CORE_CLK(core_clk), .RESET_N(reset_n), .LINK(link), .CONV_REQ(conv_req),
    .READ_EN(read_en), .READ_BITS(read_bits), .GROUP_BITS(group_bits), .DATA_WORD(data_word),
    .DATA_VALID(data_valid));
  sad_link_properties #(.CONV_CYC(CONV_CYCLES)) u_sad_link_properties (.CORE_CLK(core_clk),
    .RESET_N(reset_n), .conversion_trigger(link.conversion_trigger), .sck(link.sck), .busy(link.busy),
    .sdo(link.sdo));

  // ----------------------------------------
  // Checks and filter model
  // ----------------------------------------
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [39:0] exp_word(longint s, int cnt);
    int     sh;
    longint a;
    sh = 0;
    while ((1 << sh) < cnt && sh < 16) sh++;
    a = s >>> sh;
    if (a > 8388607) a = 8388607;
    if (a < -8388608) a = -8388608;
    return {a[23:0], (cnt > 65536) ? 16'hffff : 16'(cnt - 1)};
  endfunction

  // One conversion, sometimes with a stray trigger while busy, then a long read window
  task automatic conv(input logic en);
    logic [23:0] s;
    logic        load;
    logic        st;
    int          k;
    @(negedge core_clk);
    s = 24'($random(seed));
    sample_in = s;
    read_en = en;
    conv_req = 1'b1;
    @(negedge core_clk);
    conv_req = 1'b0;
    for (k = 0; k < 40 && link.busy !== 1'b1; k++) @(negedge core_clk);
    if (s[1:0] == 2'h0) begin
      repeat (3) @(negedge core_clk);
      conv_req = 1'b1;
      @(negedge core_clk);
      conv_req = 1'b0;
    end
    for (k = 0; k < 40 && link.busy !== 1'b0; k++) @(negedge core_clk);
    check(40'(k >= 40), 40'h0);
    check(40'(result_reg), 40'(s));
    load = cprev == 0 || cprev >= 20;
    sum += longint'(signed'(s));
    n++;
    st = en && rem == 0 && load;
    if (st) begin
      expq.push_back({(40'h1 << rbits) - 40'h1, exp_word(sum, n) >> (40 - rbits)});
      sum = 0;
      n = 0;
      rem = rbits;
    end
    act = st || (act && !load);
    cprev = (rem < gbits) ? rem : gbits;
    rem -= cprev;
    repeat (340) @(negedge core_clk);
    check(40'(read_active), 40'(act));
  endtask

  task automatic phase(input int r, input int g, input int cnt, input logic en);
    int k;
    // The host judges a finished read by its bit setting, so a read still ending must close first
    if (cprev != 0) conv(1'b0);
    rbits = r;
    gbits = g;
    read_bits = 6'(r);
    group_bits = 6'(g);
    for (k = 0; k < cnt || rem != 0; k++) conv(en);
    $display("test bits %0d group %0d enable %0b done", r, g, en);
  endtask

  always @(negedge core_clk) begin
    if (data_valid === 1'b1) begin
      check(40'(expq.size() == 0), 40'h0);
      e = expq.pop_front();
      check(data_word & e[79:40], e[39:0]);
    end
  end

  // ----------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // About 128 conversions of 364 cycles each; the limit leaves over half as much again
  initial begin
    #1500000;
    bad_count++;
    test_done();
  end

  initial begin
    {reset_n, conv_req, read_en, sample_in, sum, n, rem, cprev, act} = '0;
    read_bits = 6'h28;
    group_bits = 6'h28;
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    phase(40, 40, 6, 1'b1);
    phase(20, 20, 4, 1'b1);
    phase(24, 8, 9, 1'b1);
    phase(38, 19, 5, 1'b1);
    phase(24, 12, 6, 1'b1);
    phase(40, 40, 4, 1'b0);
    phase(40, 40, 3, 1'b1);
    phase(40, 1, 42, 1'b1);
    phase(40, 40, 2, 1'b0);
    check(40'(expq.size()), 40'h0);
    test_done();
  end
endmodule
